// [pfm_board.sv]
// Board model that drives the general purpose and alternate function sides of the pins.
`timescale 1ns/1ps
module pfm_board (
  // Pattern phase
  input  wire logic       ph,
  // Sources toward the mux
  output logic      [8:0] gp_out,
  output logic      [8:0] gp_oe,
  output logic      [8:0] af1_out,
  output logic      [8:0] af1_oe,
  output logic      [8:0] af2_out,
  output logic      [8:0] af2_oe
);
  // All patterns invert with ph, so a stuck or swapped source shows up in one of the phases.
  assign gp_out  = {9{ph}} ^ 9'h0A5;
  assign gp_oe   = {9{ph}} ^ 9'h0F0;
  assign af1_out = {9{ph}} ^ 9'h133;
  assign af1_oe  = {9{ph}} ^ 9'h1C3;
  assign af2_out = {9{ph}} ^ 9'h0CC;
  assign af2_oe  = {9{ph}} ^ 9'h15A;
endmodule

// [pfm_cfg_if.sv]
// Interface carrying decoded pin configuration from the register file to the pin mux.
`timescale 1ns/1ps
interface pfm_cfg_if #(parameter int NPIN = 9) ();
  logic [NPIN-1:0]   func_sel;
  logic [2*NPIN-1:0] choice;
  modport src (output func_sel, output choice);
  modport dst (input func_sel, input choice);
endinterface

// [pfm_pin_mux.sv]
// Per-pin steering between general purpose logic and the two alternate functions.
`timescale 1ns/1ps
module pfm_pin_mux
  import pfm_pkg::*;
#(
  parameter int NPIN = 9
) (
  // Configuration
  pfm_cfg_if.dst         cfg,
  // General purpose side
  input  wire logic [NPIN-1:0] gp_out,
  input  wire logic [NPIN-1:0] gp_oe,
  // Alternate function sides
  input  wire logic [NPIN-1:0] af1_out,
  input  wire logic [NPIN-1:0] af1_oe,
  input  wire logic [NPIN-1:0] af2_out,
  input  wire logic [NPIN-1:0] af2_oe,
  // Pin side
  output logic      [NPIN-1:0] pin_out,
  output logic      [NPIN-1:0] pin_oe
);
  // A reserved choice leaves the pin undriven so no undefined function reaches the board.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_out[i] = gp_out[i];
      pin_oe[i]  = gp_oe[i];
      if (cfg.func_sel[i]) begin
        case (pfm_choice_t'(cfg.choice[2*i +: 2]))
          PFM_AF_FIRST: begin
            pin_out[i] = af1_out[i];
            pin_oe[i]  = af1_oe[i];
          end
          PFM_AF_SECOND: begin
            pin_out[i] = af2_out[i];
            pin_oe[i]  = af2_oe[i];
          end
          default: begin
            pin_out[i] = 1'b0;
            pin_oe[i]  = 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// [pfm_pkg.sv]
// Package with register map, field layout and reset values of the pin function mux.
package pfm_pkg;
  localparam int          PFM_LOW_PINS      = 9;
  localparam int          PFM_HIGH_PINS     = 22;
  localparam int          PFM_HIGH_BASE     = 32;
  localparam int          PFM_CHOICE_W      = 2;
  localparam logic [11:0] PFM_OFS_SEL_LOW   = 12'hA90;
  localparam logic [11:0] PFM_OFS_SEL_HIGH  = 12'hA94;
  localparam logic [11:0] PFM_OFS_CHOICE    = 12'hA98;
  localparam logic [31:0] PFM_RST_SEL_LOW   = 32'h0000_0000;
  localparam logic [31:0] PFM_RST_SEL_HIGH  = 32'h0000_0000;
  localparam logic [31:0] PFM_RST_CHOICE    = 32'h0000_0000;
  localparam logic [31:0] PFM_MASK_SEL_HIGH = 32'h003F_FFFF;
  localparam logic [31:0] PFM_MASK_CHOICE   = 32'h0003_FFFF;
  typedef enum logic [1:0] {
    PFM_AF_FIRST  = 2'h0,
    PFM_AF_SECOND = 2'h1,
    PFM_AF_RES2   = 2'h2,
    PFM_AF_RES3   = 2'h3
  } pfm_choice_t;
endpackage

// [pfm_top.sv]
// APB register file and pin output stage of the pin function mux.
//
// Contract
// - A set select bit routes the pin to its chosen alternate function.
// - A clear select bit leaves the pin as ordinary general purpose I/O.
// - Low select register bit n governs pin n, pins 0 to 8.
// - High select register bit n governs pin n plus 32, pins 32 to 53.
// - Choice register holds a two-bit field per pin 0 to 8 at bits 2n+1:2n.
// - Choice 0 is first alternate, 1 second; 2 and 3 are reserved.
// - A choice field acts only while the pin is in alternate use.
// - In alternate use the alternate function decides direction and drive.
`timescale 1ns/1ps
module pfm_top
  import pfm_pkg::*;
#(
  parameter int NLOW  = PFM_LOW_PINS,
  parameter int NHIGH = PFM_HIGH_PINS
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Low pins 0 to 8
  input  wire logic [NLOW-1:0]   gp_out,
  input  wire logic [NLOW-1:0]   gp_oe,
  input  wire logic [NLOW-1:0]   af1_out,
  input  wire logic [NLOW-1:0]   af1_oe,
  input  wire logic [NLOW-1:0]   af2_out,
  input  wire logic [NLOW-1:0]   af2_oe,
  output logic      [NLOW-1:0]   pin_out,
  output logic      [NLOW-1:0]   pin_oe,
  // High pins 32 to 53: select per pin only
  output logic      [NHIGH-1:0]  high_alt_en
);
  logic [31:0]     sel_low_q;
  logic [31:0]     sel_high_q;
  logic [31:0]     choice_q;
  logic [NLOW-1:0] mux_out;
  logic [NLOW-1:0] mux_oe;

  // Apply byte strobes, then a keep mask for read-only reserved bits.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st, input logic [31:0] msk);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        v[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return (v & msk) | (old & ~msk);
  endfunction

  // The low register's reserved field is read-write, so it keeps every bit.
  wire logic        acc      = psel & penable;
  wire logic        wr       = acc & pwrite & pready;
  wire logic        hit_low  = paddr == PFM_OFS_SEL_LOW;
  wire logic        hit_high = paddr == PFM_OFS_SEL_HIGH;
  wire logic        hit_ch   = paddr == PFM_OFS_CHOICE;
  wire logic        hit      = hit_low | hit_high | hit_ch;
  wire logic [31:0] rd_mux   = hit_low  ? sel_low_q :
                               hit_high ? sel_high_q :
                               hit_ch   ? choice_q : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_low_q  <= PFM_RST_SEL_LOW;
      sel_high_q <= PFM_RST_SEL_HIGH;
      choice_q   <= PFM_RST_CHOICE;
    end else if (wr) begin
      if (hit_low)  sel_low_q  <= merge(sel_low_q, pwdata, pstrb, 32'hFFFF_FFFF);
      if (hit_high) sel_high_q <= merge(sel_high_q, pwdata, pstrb, PFM_MASK_SEL_HIGH);
      if (hit_ch)   choice_q   <= merge(choice_q, pwdata, pstrb, PFM_MASK_CHOICE);
    end
  end

  // One wait state: pready is registered, so each access phase lasts two cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= acc & ~pready & ~hit;
    end
  end

  pfm_cfg_if #(.NPIN(NLOW)) cfg ();
  assign cfg.func_sel = sel_low_q[NLOW-1:0];
  assign cfg.choice   = choice_q[2*NLOW-1:0];

  pfm_pin_mux #(.NPIN(NLOW)) u_mux (
    .cfg     (cfg.dst),
    .gp_out  (gp_out),
    .gp_oe   (gp_oe),
    .af1_out (af1_out),
    .af1_oe  (af1_oe),
    .af2_out (af2_out),
    .af2_oe  (af2_oe),
    .pin_out (mux_out),
    .pin_oe  (mux_oe)
  );

  // Pin outputs are registered, costing one cycle of latency on every path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out     <= '0;
      pin_oe      <= '0;
      high_alt_en <= '0;
    end else begin
      pin_out     <= mux_out;
      pin_oe      <= mux_oe;
      high_alt_en <= sel_high_q[NHIGH-1:0];
    end
  end

  // Per-pin mode masks for the pin checks; they decode the registers apart from the mux.
  function automatic logic [NLOW-1:0] choice_hits(input logic [31:0] ch, input logic [1:0] code);
    logic [NLOW-1:0] m;
    m = '0;
    for (int i = 0; i < NLOW; i++) begin
      m[i] = ch[2*i +: 2] == code;
    end
    return m;
  endfunction

  wire logic [NLOW-1:0] use_gp  = ~sel_low_q[NLOW-1:0];
  wire logic [NLOW-1:0] use_af1 = sel_low_q[NLOW-1:0] & choice_hits(choice_q, 2'h0);
  wire logic [NLOW-1:0] use_af2 = sel_low_q[NLOW-1:0] & choice_hits(choice_q, 2'h1);
  wire logic [NLOW-1:0] use_res = sel_low_q[NLOW-1:0] & ~use_af1 & ~use_af2;

  // Pin path checks: each pin against its chosen source one cycle earlier, or undriven for a reserved choice.
  alt_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_low_q[0] && choice_q[1:0] == 2'h0) |=> (pin_oe[0] == $past(af1_oe[0])))
    else $error("pin 0 not on first alternate");
  alt_second_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_low_q[8] && choice_q[17:16] == 2'h1) |=> (pin_out[8] == $past(af2_out[8])))
    else $error("pin 8 not on second alternate");
  gp_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_low_q[3] |=> (pin_oe[3] == $past(gp_oe[3]) && pin_out[3] == $past(gp_out[3])))
    else $error("pin 3 left general purpose path");
  choice_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!sel_low_q[5] && $changed(choice_q)) |=> (pin_out[5] == $past(gp_out[5])))
    else $error("choice affected pin 5 in gpio mode");
  reserved_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_low_q[2] && choice_q[5:4] == 2'h3) |=> !pin_oe[2])
    else $error("reserved choice drove pin 2");
  gp_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((((pin_out ^ $past(gp_out)) | (pin_oe ^ $past(gp_oe))) & $past(use_gp)) == '0))
    else $error("general purpose pin off its path");
  af1_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((((pin_out ^ $past(af1_out)) | (pin_oe ^ $past(af1_oe))) & $past(use_af1)) == '0))
    else $error("first alternate pin off its path");
  af2_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((((pin_out ^ $past(af2_out)) | (pin_oe ^ $past(af2_oe))) & $past(use_af2)) == '0))
    else $error("second alternate pin off its path");
  res_all_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (((pin_out | pin_oe) & $past(use_res)) == '0))
    else $error("reserved choice pin driven");

  // Register storage checks, and the high select path to high_alt_en.
  high_res_a: assert property (@(posedge pclk) disable iff (!presetn)
    sel_high_q[31:22] == 10'h000)
    else $error("high select reserved bits set");
  choice_res_a: assert property (@(posedge pclk) disable iff (!presetn)
    choice_q[31:18] == 14'h0000)
    else $error("choice reserved bits set");
  high_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_high && pstrb[0]) |=> ##1 (high_alt_en[0] == $past(pwdata[0], 2)))
    else $error("pin 32 select not applied");
  high_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_high && pstrb[2]) |=> (sel_high_q[21] == $past(pwdata[21])))
    else $error("pin 53 select not stored");
  high_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (high_alt_en == $past(sel_high_q[NHIGH-1:0])))
    else $error("high pin select not applied");
  low_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_low && pstrb[1]) |=> (sel_low_q[8] == $past(pwdata[8])))
    else $error("pin 8 select not stored");
  low_pin0_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_low && pstrb[0]) |=> (sel_low_q[0] == $past(pwdata[0])))
    else $error("pin 0 select not stored");
  low_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_low && pstrb[3]) |=> (sel_low_q[31:24] == $past(pwdata[31:24])))
    else $error("low select upper byte not stored");
  strobe_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_low && !pstrb[0]) |=> (sel_low_q[7:0] == $past(sel_low_q[7:0])))
    else $error("unstrobed byte changed");
  choice_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_ch && pstrb[2]) |=> (choice_q[17:16] == $past(pwdata[17:16])))
    else $error("pin 8 choice not stored");
  choice_pin0_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_ch && pstrb[0]) |=> (choice_q[1:0] == $past(pwdata[1:0])))
    else $error("pin 0 choice not stored");

  // Bus answer checks.
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready longer than one cycle");
  err_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == 32'h0000_0000))
    else $error("read data outside answer cycle");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> (pslverr == !hit))
    else $error("pslverr does not match decode");
  high_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit_high) |-> (prdata[31:22] == 10'h000))
    else $error("high select reserved bits read set");
  choice_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && hit_ch) |-> (prdata[31:18] == 14'h0000))
    else $error("choice reserved bits read set");
endmodule

// [tb_top.sv]
// Self-checking testbench for the pin function mux.
`timescale 1ns/1ps
module tb_top;
  import pfm_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ph = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, err;
  logic [8:0]  go, ge, a1o, a1e, a2o, a2e, po, pe;
  logic [21:0] hae;
  logic [8:0]  ts [6] = '{9'h000, 9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF, 9'h0AA};
  logic [17:0] tc [6] = '{18'h3FFFF, 18'h00000, 18'h15555, 18'h2AAAA, 18'h3FFFF, 18'h24924};
  int          num_errors = 0, n_checks = 0;
  always #20 pclk = ~pclk;
  pfm_board brd (.ph(ph), .gp_out(go), .gp_oe(ge), .af1_out(a1o), .af1_oe(a1e), .af2_out(a2o), .af2_oe(a2e));
  pfm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gp_out(go), .gp_oe(ge),
    .af1_out(a1o), .af1_oe(a1e), .af2_out(a2o), .af2_oe(a2e), .pin_out(po), .pin_oe(pe), .high_alt_en(hae));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk) begin
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    end
    @(posedge pclk) penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [17:0] e);
    n_checks++;
    if ({pe, po} !== e) begin
      num_errors++;
      $display("mismatch t=%0t pins got %h exp %h", $time, {pe, po}, e);
    end
  endtask
  // Expected pins from the inputs: choice 2 and 3 leave the pin undriven at 0.
  function automatic logic [17:0] pin_exp(input logic [8:0] s, input logic [17:0] c);
    logic [17:0] r;
    for (int i = 0; i < 9; i++) begin
      r[i] = !s[i] ? go[i] : c[2*i +: 2] == 2'h0 ? a1o[i] : c[2*i +: 2] == 2'h1 ? a2o[i] : 1'b0;
      r[9+i] = !s[i] ? ge[i] : c[2*i +: 2] == 2'h0 ? a1e[i] : c[2*i +: 2] == 2'h1 ? a2e[i] : 1'b0;
    end
    return r;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PFM_OFS_SEL_LOW, 32'h0, 4'hF); chk(rd, PFM_RST_SEL_LOW);
    apb(1'b0, PFM_OFS_SEL_HIGH, 32'h0, 4'hF); chk(rd, PFM_RST_SEL_HIGH);
    apb(1'b0, PFM_OFS_CHOICE, 32'h0, 4'hF); chk(rd, PFM_RST_CHOICE);
    apb(1'b1, PFM_OFS_SEL_LOW, 32'hFFFF_FFFF, 4'h2);
    apb(1'b0, PFM_OFS_SEL_LOW, 32'h0, 4'hF); chk(rd, 32'h0000_FF00);
    apb(1'b1, PFM_OFS_SEL_HIGH, 32'hFFD2_3456, 4'hF);
    apb(1'b0, PFM_OFS_SEL_HIGH, 32'h0, 4'hF); chk(rd, 32'h0012_3456);
    chk({10'h0, hae}, 32'h0012_3456);
    apb(1'b1, PFM_OFS_CHOICE, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, PFM_OFS_CHOICE, 32'h0, 4'hF); chk(rd, PFM_MASK_CHOICE);
    apb(1'b0, 12'hA9C, 32'h0, 4'hF); chk({err, rd}, {1'b1, 32'h0});
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, PFM_OFS_SEL_LOW, {23'h0, ts[k]}, 4'hF);
      apb(1'b1, PFM_OFS_CHOICE, {14'h0, tc[k]}, 4'hF);
      repeat (2) begin
        @(posedge pclk) ph <= ~ph;
        repeat (2) @(posedge pclk);
        #1 chk_pin(pin_exp(ts[k], tc[k]));
      end
    end
    $display("test pins done");
    conclude();
  end
endmodule
